// ===== core/port_crossbar_and_port0_io.v
`timescale 1ns/10ps
`include "port_xbar_regs.vh"

module port_crossbar_and_port0_io #(
  parameter PINS = 8,
  parameter NSIG = `SIG_COUNT,
  parameter IDXW = 5
) (
  input wire clock, // System clock, 250 MHz.
  input wire nrst, // Synchronous reset, active low.
  input wire [7:0] sfr_addr, // Register address.
  input wire sfr_wr, // Byte write strobe.
  input wire [7:0] sfr_wdata, // Byte write data.
  input wire sfr_bit_wr, // Single-bit write strobe.
  input wire [2:0] sfr_bit_idx, // Bit number for bit write.
  input wire sfr_bit_val, // Value for bit write.
  input wire sfr_rd, // Read strobe.
  input wire sfr_rmw, // Read belongs to a read-modify-write.
  output reg [7:0] sfr_rdata, // Read data, one cycle after sfr_rd.
  input wire [PINS-1:0] pin_skip_mask, // Pins kept out of routing.
  input wire spi_nss_pinned, // Serial peripheral uses its select.
  input wire serial_tx_line, // Serial port transmit level.
  output reg serial_rx_line, // Serial port receive level.
  input wire [NSIG-1:0] periph_out, // Routed signal output levels.
  input wire [NSIG-1:0] periph_drive, // Routed signal wants to drive.
  output reg [NSIG-1:0] periph_in, // Pin level seen by each signal.
  input wire [PINS-1:0] pin_in, // Pad input levels.
  output reg [PINS-1:0] pin_out, // Pad output levels.
  output reg [PINS-1:0] pin_oe_n, // Pad driver enable, low drives.
  output reg [PINS-1:0] pin_pullup_en, // Weak pull-up enable.
  output reg [PINS-1:0] pin_rx_en // Digital receiver enable.
);

  // ****************************************************************
  // Registers and synchroniser.
  // ****************************************************************
  reg [7:0] port0_latch_r;
  reg [7:0] port0_output_mode_r;
  reg [7:0] port0_input_mode_r;
  reg [7:0] routing_control_a_r;
  reg [7:0] routing_control_b_r;
  reg [PINS-1:0] pin_meta_r;
  reg [PINS-1:0] pin_sync_r;
  reg [7:0] bit_mask;
  reg [7:0] rdata_nxt;
  reg [NSIG-1:0] periph_in_nxt;
  reg [2:0] chan_count;
  reg [NSIG-1:0] req;
  integer k;
  integer m;

  wire xbar_en;
  wire pullup_disable;
  wire serial_port_on;
  wire [PINS-1:0] pins_read;
  wire [PINS-1:0] reserved;
  wire [PINS-1:0] pin_used;
  wire [PINS*IDXW-1:0] pin_idx;
  wire [PINS-1:0] out_nxt;
  wire [PINS-1:0] oe_n_nxt;
  wire [PINS-1:0] pullup_nxt;
  wire [PINS-1:0] rx_en_nxt;

  assign xbar_en = routing_control_b_r[`BIT_ROUTING_GLOBAL_EN];
  assign pullup_disable = routing_control_b_r[`BIT_PULLUP_DISABLE];
  assign serial_port_on =
    xbar_en & routing_control_a_r[`BIT_SERIAL_PORT_ROUTE_EN];

  // Pad inputs cross into the clock domain through two flip-flops.
  always @(posedge clock) begin
    if (!nrst) begin
      pin_meta_r <= {PINS{1'b1}};
      pin_sync_r <= {PINS{1'b1}};
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Analog pins have no receiver, so they read as one.
  assign pins_read = pin_sync_r | ~port0_input_mode_r;

  // ****************************************************************
  // Register writes.
  // ****************************************************************

  // Decodes the bit number of a single-bit write into a mask.
  always @* begin
    bit_mask = 8'h00;
    bit_mask[sfr_bit_idx] = 1'b1;
  end

  // Byte writes hit any register; bit writes hit the bit addressable
  // port latch only, and keep the other latch bits as they are.
  always @(posedge clock) begin
    if (!nrst) begin
      port0_latch_r <= `RST_PORT0_LATCH;
      port0_output_mode_r <= `RST_PORT0_OUTPUT_MODE;
      port0_input_mode_r <= `RST_PORT0_INPUT_MODE;
      routing_control_a_r <= `RST_ROUTING_CONTROL_A;
      routing_control_b_r <= `RST_ROUTING_CONTROL_B;
    end else begin
      if (sfr_wr) begin
        case (sfr_addr)
          `ADDR_PORT0_LATCH: begin
            port0_latch_r <= sfr_wdata;
          end
          `ADDR_PORT0_OUTPUT_MODE: begin
            port0_output_mode_r <= sfr_wdata;
          end
          `ADDR_PORT0_INPUT_MODE: begin
            port0_input_mode_r <= sfr_wdata;
          end
          `ADDR_ROUTING_CONTROL_A: begin
            routing_control_a_r <= sfr_wdata;
          end
          `ADDR_ROUTING_CONTROL_B: begin
            routing_control_b_r <= sfr_wdata;
          end
          default: begin
          end
        endcase
      end else if (sfr_bit_wr && sfr_addr == `ADDR_PORT0_LATCH) begin
        if (sfr_bit_val) begin
          port0_latch_r <= port0_latch_r | bit_mask;
        end else begin
          port0_latch_r <= port0_latch_r & ~bit_mask;
        end
      end
    end
  end

  // ****************************************************************
  // Register reads.
  // ****************************************************************

  // Port reads see the pins unless the access is read-modify-write.
  always @* begin
    rdata_nxt = `RD_UNMAPPED;
    case (sfr_addr)
      `ADDR_PORT0_LATCH: begin
        if (sfr_rmw) begin
          rdata_nxt = port0_latch_r;
        end else begin
          rdata_nxt = pins_read;
        end
      end
      `ADDR_PORT0_OUTPUT_MODE: begin
        rdata_nxt = port0_output_mode_r;
      end
      `ADDR_PORT0_INPUT_MODE: begin
        rdata_nxt = port0_input_mode_r;
      end
      `ADDR_ROUTING_CONTROL_A: begin
        rdata_nxt = routing_control_a_r;
      end
      `ADDR_ROUTING_CONTROL_B: begin
        rdata_nxt = routing_control_b_r;
      end
      default: begin
        rdata_nxt = `RD_UNMAPPED;
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  always @(posedge clock) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Routing requests.
  // ****************************************************************

  // Builds the request vector in priority order from the enables.
  always @* begin
    chan_count = routing_control_b_r[`FLD_CHANNEL_PIN_COUNT];
    if (chan_count > `CHANNEL_COUNT_MAX) begin
      chan_count = `CHANNEL_COUNT_MAX;
    end
    req = {NSIG{1'b0}};
    if (xbar_en) begin
      if (routing_control_a_r[`BIT_SERIAL_PERIPH_ROUTE_EN]) begin
        req[`SIG_SPI_SCK] = 1'b1;
        req[`SIG_SPI_MISO] = 1'b1;
        req[`SIG_SPI_MOSI] = 1'b1;
        req[`SIG_SPI_NSS] = spi_nss_pinned;
      end
      if (routing_control_a_r[`BIT_TWOWIRE_ROUTE_EN]) begin
        req[`SIG_SDA] = 1'b1;
        req[`SIG_SCL] = 1'b1;
      end
      req[`SIG_SYSCLK] = routing_control_a_r[`BIT_SYSCLK_OUT_ROUTE_EN];
      req[`SIG_CMP0] = routing_control_a_r[`BIT_CMP0_SYNC_ROUTE_EN];
      req[`SIG_CMP0_ASYNC] =
        routing_control_a_r[`BIT_CMP0_ASYNC_ROUTE_EN];
      req[`SIG_CMP1] = routing_control_a_r[`BIT_CMP1_SYNC_ROUTE_EN];
      req[`SIG_CMP1_ASYNC] =
        routing_control_a_r[`BIT_CMP1_ASYNC_ROUTE_EN];
      req[`SIG_TIMER0] =
        routing_control_b_r[`BIT_TIMER0_INPUT_ROUTE_EN];
      req[`SIG_TIMER1] =
        routing_control_b_r[`BIT_TIMER1_INPUT_ROUTE_EN];
      req[`SIG_COUNTER_EXT] =
        routing_control_b_r[`BIT_COUNTER_EXT_INPUT_ROUTE_EN];
      for (k = 0; k < 5; k = k + 1) begin
        if (k < chan_count) begin
          req[`SIG_CHANNEL0 + k] = 1'b1;
        end
      end
    end
  end

  // Serial port pins are held back from the priority walk.
  assign reserved = serial_port_on ?
    ((8'h01 << `SERIAL_TX_PIN) | (8'h01 << `SERIAL_RX_PIN)) :
    8'h00;

  pin_route_decoder #(
    .NSIG(NSIG),
    .PINS(PINS),
    .IDXW(IDXW)
  ) u_decoder (
    .req(req),
    .reserved(reserved),
    .skip(pin_skip_mask),
    .pin_used(pin_used),
    .pin_idx(pin_idx)
  );

  // ****************************************************************
  // Per-pin drive, pull-up and receiver control.
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      wire [IDXW-1:0] idx;
      wire sel;
      wire is_tx;
      wire is_rx;
      wire digital;
      wire twowire;
      wire push_pull;
      wire val;
      wire want;
      wire drive;

      assign idx = pin_idx[i*IDXW +: IDXW];
      assign sel = pin_used[i];
      assign is_tx = serial_port_on && (i == `SERIAL_TX_PIN);
      assign is_rx = serial_port_on && (i == `SERIAL_RX_PIN);
      assign digital = port0_input_mode_r[i];
      assign twowire = sel && (idx == `SIG_SDA || idx == `SIG_SCL);
      // Output mode only matters for digital pins.
      assign push_pull = digital & port0_output_mode_r[i] &
        ~twowire;
      // Value comes from the serial port, a routed signal or the latch.
      assign val = is_tx ? serial_tx_line :
        (sel ? periph_out[idx] : port0_latch_r[i]);
      assign want = is_tx ? 1'b1 :
        (is_rx ? 1'b0 : (sel ? periph_drive[idx] : 1'b1));
      // Open-drain drives only lows; nothing drives while disabled.
      assign drive = xbar_en & digital & want &
        (push_pull | ~val);
      assign out_nxt[i] = val;
      assign oe_n_nxt[i] = ~drive;
      // Pull-ups serve open-drain pins that are not pulling low.
      assign pullup_nxt[i] = ~pullup_disable & digital & ~push_pull &
        ~(drive & ~val);
      assign rx_en_nxt[i] = digital;
    end
  endgenerate

  // Hands each routed signal the level of the pin it was given.
  always @* begin
    periph_in_nxt = {NSIG{1'b0}};
    for (m = 0; m < PINS; m = m + 1) begin
      if (pin_used[m]) begin
        periph_in_nxt[pin_idx[m*IDXW +: IDXW]] = pins_read[m];
      end
    end
  end

  // ****************************************************************
  // Output registers.
  // ****************************************************************

  // All pad and peripheral outputs leave from flip-flops.
  always @(posedge clock) begin
    if (!nrst) begin
      pin_out <= {PINS{1'b1}};
      pin_oe_n <= {PINS{1'b1}};
      pin_pullup_en <= {PINS{1'b1}};
      pin_rx_en <= {PINS{1'b1}};
      periph_in <= {NSIG{1'b0}};
      serial_rx_line <= 1'b1;
    end else begin
      pin_out <= out_nxt;
      pin_oe_n <= oe_n_nxt;
      pin_pullup_en <= pullup_nxt;
      pin_rx_en <= rx_en_nxt;
      periph_in <= periph_in_nxt;
      serial_rx_line <= serial_port_on ?
        pins_read[`SERIAL_RX_PIN] : 1'b1;
    end
  end

endmodule

// ===== common/port_xbar_regs.vh
`ifndef PORT_XBAR_REGS_VH
`define PORT_XBAR_REGS_VH

// ****************************************************************
// Register addresses in the special function register space.
// ****************************************************************
`define ADDR_PORT0_LATCH 8'h80
`define ADDR_PORT0_OUTPUT_MODE 8'hA4
`define ADDR_ROUTING_CONTROL_A 8'hE1
`define ADDR_PORT0_INPUT_MODE 8'hF1
`define ADDR_ROUTING_CONTROL_B 8'hF2

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_PORT0_LATCH 8'hFF
`define RST_PORT0_OUTPUT_MODE 8'h00
`define RST_ROUTING_CONTROL_A 8'h00
`define RST_PORT0_INPUT_MODE 8'hFF
`define RST_ROUTING_CONTROL_B 8'h00
`define RD_UNMAPPED 8'h00

// ****************************************************************
// Field positions in routing_control_a.
// ****************************************************************
`define BIT_CMP1_ASYNC_ROUTE_EN 7
`define BIT_CMP1_SYNC_ROUTE_EN 6
`define BIT_CMP0_ASYNC_ROUTE_EN 5
`define BIT_CMP0_SYNC_ROUTE_EN 4
`define BIT_SYSCLK_OUT_ROUTE_EN 3
`define BIT_TWOWIRE_ROUTE_EN 2
`define BIT_SERIAL_PERIPH_ROUTE_EN 1
`define BIT_SERIAL_PORT_ROUTE_EN 0

// ****************************************************************
// Field positions in routing_control_b.
// ****************************************************************
`define BIT_PULLUP_DISABLE 7
`define BIT_ROUTING_GLOBAL_EN 6
`define BIT_TIMER1_INPUT_ROUTE_EN 5
`define BIT_TIMER0_INPUT_ROUTE_EN 4
`define BIT_COUNTER_EXT_INPUT_ROUTE_EN 3
`define FLD_CHANNEL_PIN_COUNT 2:0
`define CHANNEL_COUNT_MAX 3'h5

// ****************************************************************
// Fixed serial port pins and routed signal indices, by priority.
// ****************************************************************
`define SERIAL_TX_PIN 4
`define SERIAL_RX_PIN 5
`define SIG_SPI_SCK 5'h00
`define SIG_SPI_MISO 5'h01
`define SIG_SPI_MOSI 5'h02
`define SIG_SPI_NSS 5'h03
`define SIG_SDA 5'h04
`define SIG_SCL 5'h05
`define SIG_SYSCLK 5'h06
`define SIG_CMP0 5'h07
`define SIG_CMP0_ASYNC 5'h08
`define SIG_CMP1 5'h09
`define SIG_CMP1_ASYNC 5'h0A
`define SIG_TIMER0 5'h0B
`define SIG_TIMER1 5'h0C
`define SIG_COUNTER_EXT 5'h0D
`define SIG_CHANNEL0 5'h0E
`define SIG_COUNT 19

`endif

// ===== core/pin_route_decoder.v
`timescale 1ns/10ps

// Priority decoder: each requested signal, lowest index first, takes
// the lowest pin that is neither reserved, skipped nor already taken.
module pin_route_decoder #(
  parameter NSIG = 19,
  parameter PINS = 8,
  parameter IDXW = 5
) (
  input wire [NSIG-1:0] req, // Signals asking for a pin.
  input wire [PINS-1:0] reserved, // Pins held outside the priority.
  input wire [PINS-1:0] skip, // Pins software keeps out.
  output reg [PINS-1:0] pin_used, // Pin carries a routed signal.
  output reg [PINS*IDXW-1:0] pin_idx // Signal index per pin.
);

  reg [PINS-1:0] taken;
  reg [IDXW-1:0] sidx;
  reg found;
  integer s;
  integer p;

  // ****************************************************************
  // Sequential walk over signals in priority order.
  // ****************************************************************
  always @* begin
    taken = reserved | skip;
    pin_used = {PINS{1'b0}};
    pin_idx = {PINS*IDXW{1'b0}};
    sidx = {IDXW{1'b0}};
    found = 1'b0;
    for (s = 0; s < NSIG; s = s + 1) begin
      found = 1'b0;
      for (p = 0; p < PINS; p = p + 1) begin
        if (req[s] && !found && !taken[p]) begin
          taken[p] = 1'b1;
          pin_used[p] = 1'b1;
          pin_idx[p*IDXW +: IDXW] = sidx;
          found = 1'b1;
        end
      end
      sidx = sidx + {{(IDXW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== tb/port_xbar_checker.sv
`timescale 1ns/10ps

// Watches the port block from its register strobes and pad outputs.
module port_xbar_checker #(
  parameter PINS = 8
) (
  input wire clock, // System clock.
  input wire nrst, // Reset, active low.
  input wire [7:0] sfr_addr, // Register address.
  input wire sfr_wr, // Byte write.
  input wire [7:0] sfr_wdata, // Write data.
  input wire sfr_bit_wr, // Bit write.
  input wire [2:0] sfr_bit_idx, // Bit number.
  input wire sfr_bit_val, // Bit value.
  input wire sfr_rd, // Read.
  input wire sfr_rmw, // Latch read.
  input wire [7:0] sfr_rdata, // Read data.
  input wire serial_tx_line, // Transmit level.
  input wire serial_rx_line, // Receive level.
  input wire [PINS-1:0] pin_out, // Pad levels.
  input wire [PINS-1:0] pin_oe_n, // Pad enables.
  input wire [PINS-1:0] pin_pullup_en, // Pull-ups.
  input wire [PINS-1:0] pin_rx_en // Receivers.
);
  reg [7:0] lat_r;
  reg [7:0] mdin_r;
  reg [7:0] rca_r;
  reg [7:0] rcb_r;

  // ****************************************************************
  // Shadow registers
  // ****************************************************************

  // Keeps shadow copies so outputs can be tied to register contents.
  always @(posedge clock) begin
    if (!nrst) begin
      lat_r <= 8'hFF;
      mdin_r <= 8'hFF;
      rca_r <= 8'h00;
      rcb_r <= 8'h00;
    end else if (sfr_wr) begin
      case (sfr_addr)
        8'h80: lat_r <= sfr_wdata;
        8'hF1: mdin_r <= sfr_wdata;
        8'hE1: rca_r <= sfr_wdata;
        8'hF2: rcb_r <= sfr_wdata;
        default: ;
      endcase
    end else if (sfr_bit_wr && sfr_addr == 8'h80) begin
      lat_r[sfr_bit_idx] <= sfr_bit_val;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_latch_read;
    sfr_rd && sfr_rmw && sfr_addr == 8'h80;
  endsequence

  sequence s_pin_read;
    sfr_rd && !sfr_rmw && sfr_addr == 8'h80;
  endsequence

  a_rmw_latch_read:
    assert property (s_latch_read |=> sfr_rdata == $past(lat_r))
    else $error("Latch read does not return the latch.");
  a_analog_reads_one:
    assert property (s_pin_read |=>
      (~sfr_rdata & ~$past(mdin_r)) == 8'h00)
    else $error("Analog pin did not read as one.");
  a_unmapped_reads_zero:
    assert property (sfr_rd && !(sfr_addr inside {8'h80, 8'hA4, 8'hE1,
      8'hF1, 8'hF2}) |=> sfr_rdata == 8'h00)
    else $error("Unmapped address did not read zero.");
  a_route_reg_read:
    assert property (sfr_rd && sfr_addr == 8'hF2 |=>
      sfr_rdata == $past(rcb_r))
    else $error("Routing register read back wrong.");
  a_rdata_holds:
    assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("Read data changed without a read.");
  a_xbar_off_hiz:
    assert property (!rcb_r[6] |=> pin_oe_n == 8'hFF)
    else $error("Pad driven while routing is off.");
  a_pullup_disabled:
    assert property (rcb_r[7] |=> pin_pullup_en == 8'h00)
    else $error("Pull-up on while pull-ups are disabled.");
  a_analog_quiet:
    assert property (1'b1 |=> ((pin_pullup_en | pin_rx_en | ~pin_oe_n)
      & ~$past(mdin_r)) == 8'h00)
    else $error("Analog pin has pull-up, driver or receiver on.");
  a_uart_tx_pin:
    assert property (rca_r[0] && rcb_r[6] |=>
      pin_out[4] == $past(serial_tx_line))
    else $error("Transmit level not on pin four.");
  a_uart_rx_idle:
    assert property (!rca_r[0] |=> serial_rx_line)
    else $error("Receive line not idle high with the port off.");
endmodule

bind port_crossbar_and_port0_io port_xbar_checker #(.PINS(PINS)) chk (
  .clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
  .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
  .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
  .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_pullup_en(pin_pullup_en), .pin_rx_en(pin_rx_en)
);

// ===== tb/pad_model.sv
`timescale 1ns/10ps

// Pad ring: a driven pad follows the block, a released pad follows an
// outside source or its pull-up, and a floating pad toggles each cycle
// so that a stale level can never pass for a real one.
module pad_model (
  input wire clock, // Clock for the float pattern.
  input wire [7:0] pin_out, // Pad output levels.
  input wire [7:0] pin_oe_n, // Low where the block drives.
  input wire [7:0] pin_pullup_en, // Weak pull-ups.
  input wire [7:0] ext_en, // Outside source drives.
  input wire [7:0] ext_level, // Outside source level.
  output wire [7:0] pin_in // Resolved pad level.
);
  reg [7:0] float_r = 8'h55;
  wire [7:0] rel;

  // Toggles the level seen on floating pads.
  always @(posedge clock) begin
    float_r <= ~float_r;
  end

  // Resolves every pad from the enables of all parties.
  assign rel = pin_oe_n & ~ext_en;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_level)
    | (rel & pin_pullup_en) | (rel & ~pin_pullup_en & float_r);
endmodule

// ===== tb/port_crossbar_and_port0_io_tb_top.sv
`timescale 1ns/10ps

// Self-checking bench for the port routing block.
module port_crossbar_and_port0_io_tb_top;
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_bit_wr = 1'b0;
  reg [2:0] sfr_bit_idx = 3'h0;
  reg sfr_bit_val = 1'b0;
  reg sfr_rd = 1'b0;
  reg sfr_rmw = 1'b0;
  reg [7:0] pin_skip_mask = 8'h00;
  reg spi_nss_pinned = 1'b0;
  reg serial_tx_line = 1'b0;
  reg [18:0] periph_out = 19'h00000;
  reg [18:0] periph_drive = 19'h00000;
  reg [7:0] ext_en = 8'h00;
  reg [7:0] ext_level = 8'h00;
  wire [7:0] sfr_rdata, pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_rx_en;
  wire serial_rx_line;
  wire [18:0] periph_in;
  integer errors = 0;
  integer n_tests = 0;
  integer c;

  port_crossbar_and_port0_io dut (
    .clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
    .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
    .pin_skip_mask(pin_skip_mask), .spi_nss_pinned(spi_nss_pinned),
    .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line),
    .periph_out(periph_out), .periph_drive(periph_drive),
    .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .pin_rx_en(pin_rx_en)
  );

  pad_model pads (
    .clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .ext_en(ext_en),
    .ext_level(ext_level), .pin_in(pin_in)
  );

  // Clock at 250 MHz.
  always #2 clock = ~clock;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task check(input [31:0] seen, input [31:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask

  // Byte write, with an idle cycle so strobes never collide.
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
      @(posedge clock);
    end
  endtask

  task bw(input [7:0] a, input [2:0] i, input v);
    begin
      sfr_addr <= a;
      sfr_bit_idx <= i;
      sfr_bit_val <= v;
      sfr_bit_wr <= 1'b1;
      @(posedge clock);
      sfr_bit_wr <= 1'b0;
      @(posedge clock);
    end
  endtask

  // Read and compare; the data stands until the next read.
  task rc(input [7:0] a, input m, input [7:0] want);
    begin
      sfr_addr <= a;
      sfr_rmw <= m;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      @(posedge clock);
      check(sfr_rdata, want);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    begin
      check(pin_oe_n, 8'hFF);
      check(pin_rx_en, 8'hFF);
      rc(8'h80, 1'b1, 8'hFF);
      rc(8'hA4, 1'b0, 8'h00);
      rc(8'hE1, 1'b0, 8'h00);
      rc(8'hF1, 1'b0, 8'hFF);
      rc(8'hF2, 1'b0, 8'h00);
      wr(8'h81, 8'h5A);
      rc(8'h81, 1'b0, 8'h00);
    end
  endtask

  task t_gpio;
    begin
      wr(8'hF2, 8'h40);
      wr(8'hA4, 8'hFF);
      wr(8'h80, 8'hA5);
      tick(1);
      check(pin_oe_n, 8'h00);
      check(pin_out, 8'hA5);
      tick(3);
      rc(8'h80, 1'b0, 8'hA5);
      wr(8'hA4, 8'h00);
      tick(1);
      check(pin_oe_n, 8'hA5);
      check(pin_pullup_en, 8'hA5);
      tick(3);
      rc(8'h80, 1'b0, 8'hA5);
      wr(8'hF2, 8'hC0);
      tick(1);
      check(pin_pullup_en, 8'h00);
    end
  endtask

  task t_rmw;
    begin
      ext_en <= 8'hA5;
      tick(4);
      rc(8'h80, 1'b0, 8'h00);
      rc(8'h80, 1'b1, 8'hA5);
      bw(8'h80, 3'h1, 1'b1);
      rc(8'h80, 1'b1, 8'hA7);
      bw(8'hF1, 3'h0, 1'b0);
      rc(8'hF1, 1'b0, 8'hFF);
      ext_en <= 8'h00;
    end
  endtask

  task t_analog;
    begin
      wr(8'hF2, 8'h40);
      wr(8'hA4, 8'hF0);
      wr(8'hF1, 8'h0F);
      tick(1);
      check(pin_oe_n, 8'hF7);
      check(pin_pullup_en, 8'h07);
      check(pin_rx_en, 8'h0F);
      tick(3);
      rc(8'h80, 1'b0, 8'hF7);
      wr(8'hF1, 8'hFF);
    end
  endtask

  task t_route;
    begin
      wr(8'hA4, 8'hFF);
      wr(8'h80, 8'h00);
      periph_drive <= 19'h7FFFF;
      periph_out <= 19'h7FFFF;
      for (c = 0; c < 8; c = c + 1) begin
        wr(8'hF2, 8'h40 | c[7:0]);
        tick(1);
        check(pin_out, (c > 5) ? 8'h1F : (8'h01 << c) - 8'h01);
      end
      pin_skip_mask <= 8'h01;
      serial_tx_line <= 1'b1;
      wr(8'hE1, 8'h01);
      tick(1);
      check({pin_oe_n[5], pin_out & 8'hDF}, {1'b1, 8'hDE});
      ext_en <= 8'h20;
      tick(4);
      check(serial_rx_line, 1'b0);
      wr(8'hF2, 8'h07);
      tick(1);
      check(pin_oe_n, 8'hFF);
      pin_skip_mask <= 8'h00;
      ext_en <= 8'h00;
      spi_nss_pinned <= 1'b1;
      wr(8'hF2, 8'h40);
      for (c = 1; c < 8; c = c + 1) begin
        wr(8'hE1, 8'h01 << c);
        tick(1);
        if (c == 2)
          check(pin_oe_n[0], 1'b1);
        else if (c == 1)
          check(pin_out[3:0], 4'hF);
        else
          check(pin_out[0], 1'b1);
      end
      periph_drive <= 19'h00000;
      ext_en <= 8'h01;
      ext_level <= 8'h01;
      wr(8'hE1, 8'h00);
      for (c = 0; c < 3; c = c + 1) begin
        wr(8'hF2, 8'h40 | (8'h08 << c));
        tick(4);
        check(periph_in[(c == 0) ? 13 : c + 10], 1'b1);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #40000;
    errors = errors + 1;
    print_verdict;
  end

  // Main sequence: reset for 12 cycles, then every scenario.
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset;
    t_gpio;
    t_rmw;
    t_analog;
    t_route;
    print_verdict;
  end
endmodule
